// ===== rtl/scp_serial_control_port.sv
// Two-wire bus target with a register write port and a readback port
// Notes on behaviour
// [R1] Low reset pin returns every part of the port to its reset state; the pin sensor is reset by i_rst only.
// [R2] Far side holds the reset pin low at least 5 ms per reset; the bench holds it low for only 20 and 6 system clocks.
// [R3] Two targets: register write port and vertical-blanking readback port.
// [R4] Strap low: write port answers 0x40, readback answers 0x21.
// [R5] Strap high: write port answers 0x42, readback answers 0x23.
// [R6] Far side never runs the serial clock above 400 kHz; the bench host model runs it at 2.5 MHz.
// [R7] One data pin: sampled during writes, driven for acknowledge and readback.
// [R8] Only matching address bytes are acknowledged; other traffic is ignored.
`timescale 1ns/1ps
module scp_serial_control_port
(
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_reset_n,
    input  wire logic        i_bus_address_strap,
    input  wire logic        i_scl,
    input  wire logic        i_serial_data_line_in,
    output logic             o_serial_data_line_out,
    output logic             o_serial_data_line_oe_n,
    output logic             o_wr_valid,
    output logic [7:0]       o_wr_sub_addr,
    output logic [7:0]       o_wr_data,
    output logic             o_vbi_rd_strobe,
    input  wire logic [7:0]  i_vbi_data
);

    scp_line_if line ();

    scp_pkg::scp_state_t state;
    logic [3:0]          bit_cnt;
    logic [7:0]          shift;
    logic                is_read;
    logic                acked;
    logic                have_sub;
    logic [7:0]          sub_addr;
    logic                rst_int;
    logic                addr_done;
    logic                ctrl_hit;
    logic                vbi_hit;
    logic                wr_done;
    logic                rd_load;
    logic                next_hold;
    logic                next_low;

    // The sensor runs on the system reset only, so it keeps watching the pin
    scp_line_sense u_sense
    (
        .i_clock             (i_clock),
        .i_rst               (i_rst),
        .i_reset_n           (i_reset_n),
        .i_bus_address_strap (i_bus_address_strap),
        .i_scl               (i_scl),
        .i_sda               (i_serial_data_line_in),
        .line                (line.sense)
    );

    assign rst_int   = i_rst | line.pin_reset;                                // [R1]
    assign addr_done = state == scp_pkg::ST_ADDR && line.scl_fall && bit_cnt == scp_pkg::BYTE_BITS;
    assign ctrl_hit  = (shift == scp_pkg::ctrl_address(line.strap_level));    // [R4] [R5]
    assign vbi_hit   = (shift == scp_pkg::vbi_address(line.strap_level));     // [R4] [R5]
    assign wr_done   = (state == scp_pkg::ST_WR_BYTE) && line.scl_fall
                       && (bit_cnt == scp_pkg::BYTE_BITS);
    assign rd_load   = line.scl_fall && ((state == scp_pkg::ST_ADDR_ACK && is_read)
                       || (state == scp_pkg::ST_RD_ACK && acked));

    // Protocol sequencing; start and stop override any state
    always_ff @(posedge i_clock)
    begin
        if (rst_int)
        begin
            state   <= scp_pkg::ST_IDLE;                                       // [R1]
            bit_cnt <= scp_pkg::BIT_CNT_RESET;
            shift   <= scp_pkg::BYTE_RESET;
            is_read <= 1'b0;
            acked   <= 1'b0;
        end
        else if (line.start_seen)
        begin
            state   <= scp_pkg::ST_ADDR;
            bit_cnt <= scp_pkg::BIT_CNT_RESET;
        end
        else if (line.stop_seen)
        begin
            state <= scp_pkg::ST_IDLE;
        end
        else
        begin
            case (state)
                scp_pkg::ST_IDLE:
                begin
                    bit_cnt <= scp_pkg::BIT_CNT_RESET;
                end
                scp_pkg::ST_ADDR:
                begin
                    if (line.scl_rise)
                    begin
                        shift   <= {shift[6:0], line.sda_level};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if (addr_done)
                    begin
                        state   <= (ctrl_hit || vbi_hit) ? scp_pkg::ST_ADDR_ACK
                                                         : scp_pkg::ST_IDLE;  // [R8]
                        is_read <= vbi_hit;                                    // [R3]
                    end
                end
                scp_pkg::ST_ADDR_ACK:
                begin
                    if (line.scl_fall)
                    begin
                        bit_cnt <= scp_pkg::BIT_CNT_RESET;
                        state   <= is_read ? scp_pkg::ST_RD_BYTE : scp_pkg::ST_WR_BYTE;
                        if (is_read)
                        begin
                            shift <= i_vbi_data;
                        end
                    end
                end
                scp_pkg::ST_WR_BYTE:
                begin
                    if (line.scl_rise)
                    begin
                        shift   <= {shift[6:0], line.sda_level};               // [R7]
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if (wr_done)
                    begin
                        state <= scp_pkg::ST_WR_ACK;
                    end
                end
                scp_pkg::ST_WR_ACK:
                begin
                    if (line.scl_fall)
                    begin
                        bit_cnt <= scp_pkg::BIT_CNT_RESET;
                        state   <= scp_pkg::ST_WR_BYTE;
                    end
                end
                scp_pkg::ST_RD_BYTE:
                begin
                    if (line.scl_rise)
                    begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if (line.scl_fall)
                    begin
                        if (bit_cnt == scp_pkg::BYTE_BITS)
                        begin
                            state <= scp_pkg::ST_RD_ACK;
                        end
                        else
                        begin
                            shift <= {shift[6:0], 1'b0};
                        end
                    end
                end
                scp_pkg::ST_RD_ACK:
                begin
                    if (line.scl_rise)
                    begin
                        acked <= ~line.sda_level;
                    end
                    else if (line.scl_fall)
                    begin
                        bit_cnt <= scp_pkg::BIT_CNT_RESET;
                        // A not-acknowledge ends the readback until the next start
                        state   <= acked ? scp_pkg::ST_RD_BYTE : scp_pkg::ST_IDLE;
                        if (acked)
                        begin
                            shift <= i_vbi_data;
                        end
                    end
                end
                default:
                begin
                    state <= scp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Data line drive; changes just after a clock fall, or is released on a start or stop, so the host sees
    // it settled long before the next rise
    always_comb
    begin
        next_hold = 1'b1;
        next_low  = 1'b0;
        if (line.start_seen || line.stop_seen)
        begin
            next_hold = 1'b0;
        end
        else if (addr_done)
        begin
            next_hold = 1'b0;
            next_low  = ctrl_hit || vbi_hit;                                   // [R8]
        end
        else if (line.scl_fall)
        begin
            case (state)
                scp_pkg::ST_ADDR_ACK:
                begin
                    next_hold = 1'b0;
                    next_low  = is_read && !i_vbi_data[7];                     // [R7]
                end
                scp_pkg::ST_WR_BYTE:
                begin
                    next_hold = 1'b0;
                    next_low  = (bit_cnt == scp_pkg::BYTE_BITS);
                end
                scp_pkg::ST_WR_ACK:
                begin
                    next_hold = 1'b0;
                end
                scp_pkg::ST_RD_BYTE:
                begin
                    next_hold = 1'b0;
                    next_low  = (bit_cnt != scp_pkg::BYTE_BITS) && !shift[6];  // [R7]
                end
                scp_pkg::ST_RD_ACK:
                begin
                    next_hold = 1'b0;
                    next_low  = acked && !i_vbi_data[7];
                end
                default:
                begin
                    next_hold = 1'b1;
                end
            endcase
        end
    end

    // Open drain: a one is sent by releasing the line
    always_ff @(posedge i_clock)
    begin
        if (rst_int)
        begin
            o_serial_data_line_out  <= 1'b1;
            o_serial_data_line_oe_n <= 1'b1;                                   // [R1]
        end
        else if (!next_hold)
        begin
            o_serial_data_line_out  <= ~next_low;
            o_serial_data_line_oe_n <= ~next_low;
        end
    end

    // First byte after the write address is the sub-address, later bytes
    // are data to consecutive sub-addresses
    always_ff @(posedge i_clock)
    begin
        if (rst_int)
        begin
            have_sub        <= 1'b0;
            sub_addr        <= scp_pkg::BYTE_RESET;
            o_wr_valid      <= 1'b0;
            o_wr_sub_addr   <= scp_pkg::BYTE_RESET;
            o_wr_data       <= scp_pkg::BYTE_RESET;
            o_vbi_rd_strobe <= 1'b0;
        end
        else
        begin
            o_wr_valid      <= wr_done && have_sub;                            // [R3]
            o_vbi_rd_strobe <= rd_load;                                        // [R3]
            if (line.start_seen)
            begin
                have_sub <= 1'b0;
            end
            else if (wr_done && !have_sub)
            begin
                have_sub <= 1'b1;
                sub_addr <= shift;
            end
            else if (wr_done)
            begin
                o_wr_sub_addr <= sub_addr;
                o_wr_data     <= shift;
                sub_addr      <= sub_addr + scp_pkg::SUBADDR_STEP;
            end
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (rst_int);

    sequence s_ack_low;
        !o_serial_data_line_oe_n && !o_serial_data_line_out;
    endsequence

    sequence s_released;
        o_serial_data_line_oe_n;
    endsequence

    a_reset_to_idle: assert property (disable iff (1'b0) rst_int |=> // [R1]
        (state == scp_pkg::ST_IDLE) && !o_wr_valid ##0 s_released)
        else $error("port not idle after reset");
    a_ctrl_addr_low: assert property (addr_done && !line.strap_level // [R4]
        && shift == scp_pkg::CTRL_ADDR_STRAP_LOW |=> s_ack_low ##0 state == scp_pkg::ST_ADDR_ACK)
        else $error("write address not acknowledged with strap low");
    a_vbi_addr_high: assert property (addr_done && line.strap_level // [R5]
        && shift == scp_pkg::VBI_ADDR_STRAP_HIGH |=> s_ack_low ##0 is_read)
        else $error("readback address not acknowledged with strap high");
    a_foreign_ignored: assert property (addr_done && !ctrl_hit && !vbi_hit // [R8]
        |=> s_released ##0 state == scp_pkg::ST_IDLE)
        else $error("foreign address acknowledged");
    a_readback_load: assert property (state == scp_pkg::ST_ADDR_ACK && is_read // [R3]
        && line.scl_fall |=> o_vbi_rd_strobe ##1 !o_vbi_rd_strobe)
        else $error("readback byte not fetched");
    a_ack_released: assert property (state == scp_pkg::ST_WR_ACK && line.scl_fall // [R7]
        |=> s_released)
        else $error("data line held after acknowledge");
    a_idle_no_drive: assert property (state == scp_pkg::ST_IDLE |-> s_released) // [R7]
        else $error("data line driven while idle");

endmodule : scp_serial_control_port

// ===== common/scp_pkg.sv
// Constants, state encoding and address helpers for the serial control port
package scp_pkg;

    localparam logic [7:0] CTRL_ADDR_STRAP_LOW  = 8'h40;
    localparam logic [7:0] CTRL_ADDR_STRAP_HIGH = 8'h42;
    localparam logic [7:0] VBI_ADDR_STRAP_LOW   = 8'h21;
    localparam logic [7:0] VBI_ADDR_STRAP_HIGH  = 8'h23;

    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    localparam logic [7:0] BYTE_RESET    = 8'h00;
    localparam logic [7:0] SUBADDR_STEP  = 8'h01;

    typedef enum logic [6:0]
    {
        ST_IDLE     = 7'h01,
        ST_ADDR     = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_WR_BYTE  = 7'h08,
        ST_WR_ACK   = 7'h10,
        ST_RD_BYTE  = 7'h20,
        ST_RD_ACK   = 7'h40
    } scp_state_t;

    // Full address byte, direction bit included, of the register write target
    function automatic logic [7:0] ctrl_address(input logic strap);
        return strap ? CTRL_ADDR_STRAP_HIGH : CTRL_ADDR_STRAP_LOW;
    endfunction : ctrl_address

    // Full address byte, direction bit included, of the readback target
    function automatic logic [7:0] vbi_address(input logic strap);
        return strap ? VBI_ADDR_STRAP_HIGH : VBI_ADDR_STRAP_LOW;
    endfunction : vbi_address

endpackage : scp_pkg

// ===== common/scp_line_if.sv
// Synchronised line events passed from the pin sensor to the protocol core
`timescale 1ns/1ps
interface scp_line_if;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic sda_level;
    logic strap_level;
    logic pin_reset;

    modport sense
    (
        output scl_rise,
        output scl_fall,
        output start_seen,
        output stop_seen,
        output sda_level,
        output strap_level,
        output pin_reset
    );

    modport core
    (
        input scl_rise,
        input scl_fall,
        input start_seen,
        input stop_seen,
        input sda_level,
        input strap_level,
        input pin_reset
    );
endinterface : scp_line_if

// ===== rtl/scp_line_sense.sv
// Pin synchronisers and bus edge, start and stop detection
`timescale 1ns/1ps
module scp_line_sense
(
    input  wire logic  i_clock,
    input  wire logic  i_rst,
    input  wire logic  i_reset_n,
    input  wire logic  i_bus_address_strap,
    input  wire logic  i_scl,
    input  wire logic  i_sda,
    scp_line_if.sense  line
);

    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic sda_meta;
    logic sda_sync;
    logic sda_prev;
    logic rstn_meta;
    logic rstn_sync;
    logic strap_meta;
    logic strap_sync;

    // Idle bus lines are high, so reset to high to avoid a false start
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            scl_meta   <= 1'b1;
            scl_sync   <= 1'b1;
            sda_meta   <= 1'b1;
            sda_sync   <= 1'b1;
            rstn_meta  <= 1'b1;
            rstn_sync  <= 1'b1;
            strap_meta <= 1'b0;
            strap_sync <= 1'b0;
        end
        else
        begin
            scl_meta   <= i_scl;
            scl_sync   <= scl_meta;
            sda_meta   <= i_sda;
            sda_sync   <= sda_meta;
            rstn_meta  <= i_reset_n;
            rstn_sync  <= rstn_meta;
            strap_meta <= i_bus_address_strap;
            strap_sync <= strap_meta;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            scl_prev         <= 1'b1;
            sda_prev         <= 1'b1;
            line.scl_rise    <= 1'b0;
            line.scl_fall    <= 1'b0;
            line.start_seen  <= 1'b0;
            line.stop_seen   <= 1'b0;
            line.sda_level   <= 1'b1;
            line.strap_level <= 1'b0;
            line.pin_reset   <= 1'b0;
        end
        else
        begin
            scl_prev         <= scl_sync;
            sda_prev         <= sda_sync;
            line.scl_rise    <= scl_sync & ~scl_prev;
            line.scl_fall    <= ~scl_sync & scl_prev;
            line.start_seen  <= scl_sync & scl_prev & sda_prev & ~sda_sync;
            line.stop_seen   <= scl_sync & scl_prev & ~sda_prev & sda_sync;
            line.sda_level   <= sda_sync;
            line.strap_level <= strap_sync;
            line.pin_reset   <= ~rstn_sync;                    // [R1]
        end
    end

endmodule : scp_line_sense

// ===== tb/scp_host_model.sv
// Bus controller model: drives the serial clock and its side of the open-drain data line
`timescale 1ns/1ps
module scp_host_model
(
    input  wire logic i_clock,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe_n
);
    // Four system clocks per phase: faster than the device limit, to keep the run short
    localparam int PHASE = 4;

    initial
    begin
        o_scl      = 1'b1;
        o_sda_oe_n = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge i_clock);
    endtask : tick

    // Data moves only while the clock is low; a 1 is sent by releasing the line
    task automatic put_bit(input logic b, output logic seen);
        tick(PHASE / 2);
        o_sda_oe_n = b;
        tick(PHASE / 2);
        o_scl = 1'b1;
        tick(PHASE / 2);
        seen = i_sda;
        tick(PHASE / 2);
        o_scl = 1'b0;
    endtask : put_bit

    // Waits a full phase so a trailing acknowledge is gone before the clock rises
    task automatic bus_start();
        o_sda_oe_n = 1'b1;
        tick(PHASE);
        o_scl = 1'b1;
        tick(PHASE);
        o_sda_oe_n = 1'b0;
        tick(PHASE);
        o_scl = 1'b0;
    endtask : bus_start

    // Clock is left standing high afterwards
    task automatic bus_stop();
        o_sda_oe_n = 1'b0;
        tick(PHASE / 2);
        o_scl = 1'b1;
        tick(PHASE);
        o_sda_oe_n = 1'b1;
        tick(PHASE);
    endtask : bus_stop

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask : send_byte

    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(1'b1, d[i]);
        put_bit(~ack, s);
    endtask : recv_byte
endmodule : scp_host_model

// ===== tb/testbench.sv
// Self-checking bench for the two-wire control port
`timescale 1ns/1ps
module testbench;
    logic        i_clock;
    logic        i_rst;
    logic        i_reset_n;
    logic        strap;
    logic        scl;
    logic        host_oe_n;
    logic        dev_out;
    logic        dev_oe_n;
    logic        sda;
    logic        wr_valid;
    logic [7:0]  wr_sub;
    logic [7:0]  wr_data;
    logic        rd_strobe;
    logic [7:0]  vbi_data;
    logic [15:0] exp_wr[$];
    logic [7:0]  exp_rd[$];
    int          fail_count = 0;
    int          n_compared = 0;
    integer      seed = 56575;
    logic        ack;
    logic [7:0]  got;
    logic [7:0]  ctrl_a;
    logic [7:0]  vbi_a;

    // Pull-up: low whenever either party pulls
    assign sda = (dev_oe_n | dev_out) & host_oe_n;

    scp_serial_control_port dut
    (
        .i_clock                 (i_clock),
        .i_rst                   (i_rst),
        .i_reset_n               (i_reset_n),
        .i_bus_address_strap     (strap),
        .i_scl                   (scl),
        .i_serial_data_line_in   (sda),
        .o_serial_data_line_out  (dev_out),
        .o_serial_data_line_oe_n (dev_oe_n),
        .o_wr_valid              (wr_valid),
        .o_wr_sub_addr           (wr_sub),
        .o_wr_data               (wr_data),
        .o_vbi_rd_strobe         (rd_strobe),
        .i_vbi_data              (vbi_data)
    );

    scp_host_model host
    (
        .i_clock    (i_clock),
        .i_sda      (sda),
        .o_scl      (scl),
        .o_sda_oe_n (host_oe_n)
    );

    initial
    begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // Reference model: writes are expected in order; each consumed byte is the readback source
    always @(negedge i_clock)
    begin
        if (wr_valid === 1'b1)
        begin
            if (exp_wr.size() == 0)
                check("wr_stray", 8'h01, 8'h00);
            else
            begin
                check("wr_sub", wr_sub, exp_wr[0][15:8]);
                check("wr_data", wr_data, exp_wr[0][7:0]);
                void'(exp_wr.pop_front());
            end
        end
        if (rd_strobe === 1'b1)
        begin
            exp_rd.push_back(vbi_data);
            vbi_data = 8'($random(seed));
        end
    end

    task automatic write_txn(input logic [7:0] addr, input logic [7:0] sub, input int n);
        logic [7:0] d;
        host.bus_start();
        host.send_byte(addr, ack);
        check("wr_addr_ack", {7'h00, ack}, 8'h01);
        host.send_byte(sub, ack);
        check("sub_ack", {7'h00, ack}, 8'h01);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($random(seed));
            exp_wr.push_back({sub + 8'(i), d});
            host.send_byte(d, ack);
            check("data_ack", {7'h00, ack}, 8'h01);
        end
        host.bus_stop();
        check("wr_left", 8'(exp_wr.size()), 8'h00);
    endtask : write_txn

    // Host acknowledges every byte but the last, which ends the transfer
    task automatic read_txn(input logic [7:0] addr, input int n);
        host.bus_start();
        host.send_byte(addr, ack);
        check("rd_addr_ack", {7'h00, ack}, 8'h01);
        for (int i = 0; i < n; i++)
        begin
            host.recv_byte(i < n - 1, got);
            if (exp_rd.size() != 1)
            begin
                check("rd_strobes", 8'(exp_rd.size()), 8'h01);
                exp_rd.delete();
            end
            else
                check("rd_byte", got, exp_rd.pop_front());
        end
        host.bus_stop();
        check("rd_left", 8'(exp_rd.size()), 8'h00);
    endtask : read_txn

    task automatic bad_txn(input logic [7:0] addr);
        host.bus_start();
        host.send_byte(addr, ack);
        check("bad_addr_ack", {7'h00, ack}, 8'h00);
        host.bus_stop();
        check("bad_rd", 8'(exp_rd.size()), 8'h00);
    endtask : bad_txn

    initial
    begin
        i_rst     = 1'b1;
        i_reset_n = 1'b0;
        strap     = 1'b0;
        vbi_data  = 8'($random(seed));
        repeat (20) @(negedge i_clock);
        check("init_oe_n", {7'h00, dev_oe_n}, 8'h01);
        check("init_sub", wr_sub, 8'h00);
        i_rst     = 1'b0;
        i_reset_n = 1'b1;
        repeat (8) @(negedge i_clock);
        for (int s = 0; s < 2; s++)
        begin
            strap  = s[0];
            ctrl_a = s ? scp_pkg::CTRL_ADDR_STRAP_HIGH : scp_pkg::CTRL_ADDR_STRAP_LOW;
            vbi_a  = s ? scp_pkg::VBI_ADDR_STRAP_HIGH : scp_pkg::VBI_ADDR_STRAP_LOW;
            repeat (6) @(negedge i_clock);
            write_txn(ctrl_a, s ? 8'($random(seed)) : 8'hfe, 3);
            read_txn(vbi_a, 3);
            bad_txn(ctrl_a ^ 8'h02);
            bad_txn(vbi_a ^ 8'h02);
            bad_txn(ctrl_a | 8'h01);
            bad_txn(vbi_a & 8'hfe);
            bad_txn(8'($random(seed)) | 8'h80);
        end
        // Reset pin pulled in mid-transfer, with the bus clock parked low
        host.bus_start();
        host.send_byte(ctrl_a, ack);
        host.send_byte(8'h33, ack);
        // Short pulse: the port holds no minimum-width counter
        i_reset_n = 1'b0;
        repeat (6) @(negedge i_clock);
        check("rst_oe_n", {7'h00, dev_oe_n}, 8'h01);
        check("rst_sub", wr_sub, 8'h00);
        check("rst_data", wr_data, 8'h00);
        i_reset_n = 1'b1;
        repeat (6) @(negedge i_clock);
        host.send_byte(8'h5a, ack);
        check("post_rst_ack", {7'h00, ack}, 8'h00);
        host.bus_stop();
        write_txn(ctrl_a, 8'h10, 1);
        // Repeated start: a write cut short after its sub-address, then a read
        host.bus_start();
        host.send_byte(ctrl_a, ack);
        check("rs_addr_ack", {7'h00, ack}, 8'h01);
        host.send_byte(8'h20, ack);
        check("rs_sub_ack", {7'h00, ack}, 8'h01);
        read_txn(vbi_a, 2);
        test_done();
    end

    // Whole run needs about 3250 cycles
    initial
    begin
        repeat (20000) @(posedge i_clock);
        fail_count++;
        test_done();
    end
endmodule : testbench
